/* File: hw/fan_tach_map.svh */
// Function
// - Count register holds the 8-bit speed count, valid only while monitoring is enabled.
// - A count is published only after one whole fan revolution was seen, or as all-ones once the counter saturates.
// - Count scales so RPM equals 1,200,000 over count times divisor.
// - Count reads zero until the first revolution has been measured or the counter has saturated.
// - Counter saturates at all-ones when the fan is slow or stopped.
// - Polled mode refreshes the count once per revolution.
// - Interrupt mode refreshes per revolution until an interrupt, then holds.
// - Clearing the interrupt zeroes the count and restarts measurement.
// - Monitor enable turns the pin into a tachometer input.
// - Enabled monitoring overrides other pin setups except bypass bits 6 and 5.
// - Set bypass bits make the odd tachometer pin drive as an output.
// - With monitoring disabled, other control bits have no pin effect.
// - Tachometer pulses gate a 20 kHz base into an 8-bit counter.
// - Control bits 1:0 select the divisor, two pulses per revolution.
// - Tachometer input is filtered to tolerate slow edges.
// - Monitor enable is read/write bit 7, reset zero.
// - Interrupt enable is read/write bit 6, reset zero.
// - With interrupt enabled, counter at or above the limit raises an interrupt.
// - Interrupt drives the active-low output and loads the control address as source.
// - Divisor codes 0..3 mean 1, 2, 4, 8 for 8000 to 1000 RPM.
`ifndef FAN_TACH_MAP_SVH
`define FAN_TACH_MAP_SVH

// ****************************************
// Register indices, byte address is 4x
// ****************************************
`define IDX_SPEED_LIMIT 7'h4D
`define IDX_SPEED_COUNT 7'h4A
`define IDX_SPEED_CONTROL 7'h4C
`define IDX_INT_SOURCE 7'h50

// ****************************************
// Fields and reset values
// ****************************************
`define CTRL_EN_BIT 7
`define CTRL_IE_BIT 6
`define CTRL_DIV_HI 1
`define CTRL_DIV_LO 0
`define BYPASS_HI 6
`define BYPASS_LO 5
`define CTRL_RESET 8'h00
`define COUNT_RESET 8'h00
`define LIMIT_RESET 8'h00
`define SOURCE_NONE 8'h00
`define COUNT_MAX 8'hFF

// ****************************************
// Timing
// ****************************************
`define CLK_FREQ_HZ 25000000
`define TICK_FREQ_HZ 20000
`define TICK_CYCLES (`CLK_FREQ_HZ / `TICK_FREQ_HZ)
`define FILT_TIME_NS 10000
`define CLK_PERIOD_NS 40
`define FILT_CYCLES (`FILT_TIME_NS / `CLK_PERIOD_NS)

`endif

/* File: hw/fan_tach_pkg.sv */
package fan_tach_pkg;

  typedef struct packed {
    logic enable;
    logic intEnable;
    logic [1:0] divSel;
  } ctrl_t;

  typedef struct packed {
    logic value;
    logic oe;
  } pin_drive_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_WAIT_FIRST = 3'b010,
    ST_MEASURE = 3'b100
  } meas_state_t;

endpackage

/* File: hw/tach_filter.sv */
`timescale 1ns/1ps
`include "fan_tach_map.svh"
module tach_filter (
  input wire logic clk, // Core clock
  input wire logic rst_b, // Async reset, active low
  input wire logic tachRaw, // Raw pin level
  output logic tachRise // One-cycle pulse on filtered rise
);
  localparam logic [8:0] FILT_LAST = 9'(`FILT_CYCLES - 1);
  logic syncA_ff;
  logic syncB_ff;
  logic clean_ff;
  logic [8:0] stable_ff;
  logic rise_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_ff <= 1'b1;
      syncB_ff <= 1'b1;
    end else begin
      syncA_ff <= tachRaw;
      syncB_ff <= syncA_ff;
    end
  end

  // Level must hold for the whole filter time before it is accepted
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clean_ff <= 1'b1;
      stable_ff <= 9'h000;
      rise_ff <= 1'b0;
    end else begin
      rise_ff <= 1'b0;
      if (syncB_ff == clean_ff) begin
        stable_ff <= 9'h000;
      end else if (stable_ff == FILT_LAST) begin
        clean_ff <= syncB_ff;
        rise_ff <= syncB_ff;
        stable_ff <= 9'h000;
      end else begin
        stable_ff <= stable_ff + 9'h001;
      end
    end
  end

  assign tachRise = rise_ff;
endmodule

/* File: hw/tach_prescaler.sv */
`timescale 1ns/1ps
`include "fan_tach_map.svh"
module tach_prescaler (
  input wire logic clk, // Core clock
  input wire logic rst_b, // Async reset, active low
  input wire logic restart, // Restart both stages
  input wire logic [1:0] divSel, // Divisor code
  output logic tick // Counting tick pulse
);
  localparam logic [10:0] BASE_LAST = 11'(`TICK_CYCLES - 1);
  logic [10:0] base_ff;
  logic [2:0] div_ff;
  logic baseTick;
  logic [2:0] divLast;
  logic tick_ff;

  assign baseTick = (base_ff == BASE_LAST);
  assign divLast = 3'((4'h1 << divSel) - 4'h1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      base_ff <= 11'h000;
    end else if (restart || baseTick) begin
      base_ff <= 11'h000;
    end else begin
      base_ff <= base_ff + 11'h001;
    end
  end

  // 20 kHz base further divided by the selected divisor
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_ff <= 3'h0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (restart) begin
        div_ff <= 3'h0;
      end else if (baseTick) begin
        if (div_ff >= divLast) begin
          div_ff <= 3'h0;
          tick_ff <= 1'b1;
        end else begin
          div_ff <= div_ff + 3'h1;
        end
      end
    end
  end

  assign tick = tick_ff;
endmodule

/* File: hw/fan_tach_speed_monitor.sv */
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`include "fan_tach_map.svh"
module fan_tach_speed_monitor (
  input wire logic clk, // Core clock, 25 MHz
  input wire logic rst_b, // Async reset, active low
  input wire logic [8:0] address, // Avalon byte address
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [31:0] writedata, // Avalon write data
  input wire logic [3:0] byteenable, // Avalon byte enables
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait request
  input wire logic tachPinIn, // Tachometer pin level
  input wire fan_tach_pkg::pin_drive_t gpioDrive, // Drive from other pin setup
  input wire logic [7:0] pinBitCtrl, // Pin bit control register
  input wire logic bypassValue, // Bypass output level
  output fan_tach_pkg::pin_drive_t pinDrive, // Resolved pin drive
  output logic intOut_b // Interrupt, active low
);
  import fan_tach_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic ack_ff;
  logic [6:0] regIdx;
  logic reqActive;
  logic acceptWrite;
  logic acceptRead;
  logic [31:0] readdata_ff;
  logic [31:0] nxt_readdata;

  ctrl_t ctrl_ff;
  logic [7:0] speedLimit_ff;
  logic [7:0] speedCount_ff;
  logic [7:0] intSource_ff;
  logic intPending_ff;

  meas_state_t state_ff;
  meas_state_t nxt_state;
  logic [7:0] tickCnt_ff;
  logic halfRev_ff;
  logic tachRise;
  logic tick;
  logic restart;
  logic intClear;
  logic intSet;
  logic revDone;
  logic cntSaturated;
  logic prescRestart;
  logic bypassOn;
  pin_drive_t pinDrive_ff;
  pin_drive_t nxt_pinDrive;

  // ****************************************
  // Bus slave
  // ****************************************
  assign regIdx = address[8:2];
  assign reqActive = read || write;
  assign waitrequest = reqActive && !ack_ff;
  assign acceptWrite = write && ack_ff && byteenable[0];
  assign acceptRead = read && !ack_ff;

  // One wait state per access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= reqActive && !ack_ff;
    end
  end

  always_comb begin
    nxt_readdata = 32'h0000_0000;
    case (regIdx)
      `IDX_SPEED_LIMIT: begin
        nxt_readdata[7:0] = speedLimit_ff;
      end
      `IDX_SPEED_COUNT: begin
        nxt_readdata[7:0] = speedCount_ff;
      end
      `IDX_SPEED_CONTROL: begin
        nxt_readdata[`CTRL_EN_BIT] = ctrl_ff.enable;
        nxt_readdata[`CTRL_IE_BIT] = ctrl_ff.intEnable;
        nxt_readdata[`CTRL_DIV_HI:`CTRL_DIV_LO] = ctrl_ff.divSel;
      end
      `IDX_INT_SOURCE: begin
        nxt_readdata[7:0] = intSource_ff;
      end
      default: begin
        nxt_readdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata_ff <= 32'h0000_0000;
    end else if (acceptRead) begin
      readdata_ff <= nxt_readdata;
    end
  end

  assign readdata = readdata_ff;

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= ctrl_t'(4'h0);
    end else if (acceptWrite && regIdx == `IDX_SPEED_CONTROL) begin
      ctrl_ff.enable <= writedata[`CTRL_EN_BIT];
      ctrl_ff.intEnable <= writedata[`CTRL_IE_BIT];
      ctrl_ff.divSel <= writedata[`CTRL_DIV_HI:`CTRL_DIV_LO];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      speedLimit_ff <= `LIMIT_RESET;
    end else if (acceptWrite && regIdx == `IDX_SPEED_LIMIT) begin
      speedLimit_ff <= writedata[7:0];
    end
  end

  // A write to the source register with byteenable[0] set clears the interrupt
  assign intClear = acceptWrite && regIdx == `IDX_INT_SOURCE;

  // ****************************************
  // Pin configuration
  // ****************************************
  assign bypassOn = |pinBitCtrl[`BYPASS_HI:`BYPASS_LO];

  always_comb begin
    nxt_pinDrive = gpioDrive;
    if (ctrl_ff.enable) begin
      if (bypassOn) begin
        nxt_pinDrive.value = bypassValue;
        nxt_pinDrive.oe = 1'b1;
      end else begin
        nxt_pinDrive.value = 1'b0;
        nxt_pinDrive.oe = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinDrive_ff <= pin_drive_t'(2'b00);
    end else begin
      pinDrive_ff <= nxt_pinDrive;
    end
  end

  assign pinDrive = pinDrive_ff;

  // ****************************************
  // Input conditioning and time base
  // ****************************************
  tach_filter u_filter (
    .clk(clk),
    .rst_b(rst_b),
    .tachRaw(tachPinIn),
    .tachRise(tachRise)
  );

  assign restart = !ctrl_ff.enable || intClear;
  assign prescRestart = restart || (state_ff == ST_WAIT_FIRST && tachRise);

  tach_prescaler u_prescaler (
    .clk(clk),
    .rst_b(rst_b),
    .restart(prescRestart),
    .divSel(ctrl_ff.divSel),
    .tick(tick)
  );

  // ****************************************
  // Measurement sequence
  // ****************************************
  // Two tach pulses make one revolution
  assign revDone = (state_ff == ST_MEASURE) && tachRise && halfRev_ff;
  assign cntSaturated = (tickCnt_ff == `COUNT_MAX);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OFF: begin
        if (ctrl_ff.enable) begin
          nxt_state = ST_WAIT_FIRST;
        end
      end
      ST_WAIT_FIRST: begin
        if (tachRise) begin
          nxt_state = ST_MEASURE;
        end
      end
      ST_MEASURE: begin
        nxt_state = ST_MEASURE;
      end
      default: begin
        nxt_state = ST_OFF;
      end
    endcase
    if (!ctrl_ff.enable) begin
      nxt_state = ST_OFF;
    end else if (intClear) begin
      nxt_state = ST_WAIT_FIRST;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      halfRev_ff <= 1'b0;
    end else if (restart || state_ff != ST_MEASURE) begin
      halfRev_ff <= 1'b0;
    end else if (tachRise) begin
      halfRev_ff <= !halfRev_ff;
    end
  end

  // Saturating 8-bit count of gated ticks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt_ff <= 8'h00;
    end else if (restart || state_ff == ST_OFF) begin
      tickCnt_ff <= 8'h00;
    end else if (revDone || (state_ff == ST_WAIT_FIRST && tachRise)) begin
      tickCnt_ff <= 8'h00;
    end else if (tick && !cntSaturated) begin
      tickCnt_ff <= tickCnt_ff + 8'h01;
    end
  end

  // ****************************************
  // Published count
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      speedCount_ff <= `COUNT_RESET;
    end else if (restart) begin
      speedCount_ff <= `COUNT_RESET;
    end else if (intPending_ff) begin
      speedCount_ff <= speedCount_ff;
    end else if (revDone) begin
      speedCount_ff <= tickCnt_ff;
    end else if (state_ff != ST_OFF && cntSaturated) begin
      speedCount_ff <= `COUNT_MAX;
    end
  end

  // ****************************************
  // Interrupt
  // ****************************************
  // Counter is being zeroed by a restart, so its old value must not re-arm the flag
  assign intSet = ctrl_ff.enable && ctrl_ff.intEnable && state_ff != ST_OFF && !restart &&
                  (tickCnt_ff >= speedLimit_ff);

  // A clear wins over a set in the same cycle, since restart masks intSet
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      intPending_ff <= 1'b0;
    end else if (intSet) begin
      intPending_ff <= 1'b1;
    end else if (intClear || !ctrl_ff.enable) begin
      intPending_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      intSource_ff <= `SOURCE_NONE;
    end else if (intSet) begin
      intSource_ff <= {1'b0, `IDX_SPEED_CONTROL};
    end else if (intClear || !ctrl_ff.enable) begin
      intSource_ff <= `SOURCE_NONE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      intOut_b <= 1'b1;
    end else begin
      intOut_b <= !(intSet || (intPending_ff && !intClear && ctrl_ff.enable));
    end
  end
endmodule

/* File: testbench/fan_tach_monitor_sva.sv */
`timescale 1ns/1ps
`include "fan_tach_map.svh"
module fan_tach_monitor_sva (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic [8:0] address, // Bus address
  input wire logic read, // Bus read
  input wire logic write, // Bus write
  input wire logic [31:0] writedata, // Write data
  input wire logic [3:0] byteenable, // Lanes
  input wire logic [31:0] readdata, // Read data
  input wire logic waitrequest, // Stall
  input wire logic tachPinIn, // Tach pin
  input wire fan_tach_pkg::pin_drive_t gpioDrive, // Other drive
  input wire logic [7:0] pinBitCtrl, // Bit control
  input wire logic bypassValue, // Bypass level
  input wire fan_tach_pkg::pin_drive_t pinDrive, // Pin drive
  input wire logic intOut_b // Interrupt
);
  import fan_tach_pkg::*;
  logic enSh_ff;
  logic ieSh_ff;
  logic [1:0] divSh_ff;
  wire ctrlWr = write && !waitrequest && byteenable[0] && address[8:2] == `IDX_SPEED_CONTROL;
  wire rdDone = read && !waitrequest;
  // ****************************************
  // Shadow of the control register
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enSh_ff <= 1'b0;
      ieSh_ff <= 1'b0;
      divSh_ff <= 2'h0;
    end else if (ctrlWr) begin
      enSh_ff <= writedata[7];
      ieSh_ff <= writedata[6];
      divSh_ff <= writedata[1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_wait_first: assert property ($rose(read || write) |-> waitrequest)
    else $error("no wait state on new request");
  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("wait state longer than one cycle");
  a_idle_ready: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest while idle");
  a_upper_zero: assert property (rdDone |-> readdata[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  a_ctrl_read: assert property (
    rdDone && address[8:2] == `IDX_SPEED_CONTROL |->
    readdata[7:0] == {enSh_ff, ieSh_ff, 4'h0, divSh_ff}) else $error("control readback wrong");
  a_pin_gpio: assert property (
    $past(rst_b, 2) && !$past(enSh_ff) && !$past(enSh_ff, 2) |-> pinDrive == $past(gpioDrive))
    else $error("pin not following other setup");
  a_pin_bypass: assert property (
    $past(enSh_ff) && $past(enSh_ff, 2) && $past(pinBitCtrl[6:5]) != 2'h0 |->
    pinDrive == {$past(bypassValue), 1'b1}) else $error("bypass drive wrong");
  a_pin_input: assert property (
    $past(enSh_ff) && $past(enSh_ff, 2) && $past(pinBitCtrl[6:5]) == 2'h0 |-> !pinDrive.oe)
    else $error("monitor pin still driven");
  a_int_gate: assert property (!$past(enSh_ff) && !$past(enSh_ff, 2) |-> intOut_b)
    else $error("interrupt while monitor off");
  a_int_source: assert property (
    rdDone && address[8:2] == `IDX_INT_SOURCE && !$past(intOut_b) |-> readdata[7:0] == 8'h4C)
    else $error("interrupt source wrong");
  cover property (!intOut_b);
  cover property (rdDone && address[8:2] == `IDX_SPEED_COUNT && readdata[7:0] != 8'h00);
  cover property (pinDrive.oe && enSh_ff);
endmodule
bind fan_tach_speed_monitor fan_tach_monitor_sva u_sva (.clk, .rst_b, .address, .read, .write,
  .writedata, .byteenable, .readdata, .waitrequest, .tachPinIn, .gpioDrive, .pinBitCtrl,
  .bypassValue, .pinDrive, .intOut_b);

/* File: testbench/fan_tach_model.sv */
`timescale 1ns/1ps
module fan_tach_model (
  input wire logic clk, // Clock
  input wire logic runFan, // Fan turning
  input wire logic [15:0] halfCycles, // Half pulse period
  output logic tachPinIn // Tach output
);
  int cnt;
  initial tachPinIn = 1'b1;
  // ****************************************
  // Pulse train, pulled high when stopped
  // ****************************************
  always @(posedge clk) begin
    if (!runFan) begin
      cnt <= 0;
      tachPinIn <= 1'b1;
    end else if (cnt + 1 >= int'(halfCycles)) begin
      cnt <= 0;
      tachPinIn <= ~tachPinIn;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`include "fan_tach_map.svh"
module testbench;
  import fan_tach_pkg::*;
  logic clk, rst_b, read, write, waitrequest, tachPinIn, bypassValue, intOut_b, runFan;
  logic [8:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [7:0] pinBitCtrl, rd, held;
  logic [15:0] halfCycles;
  pin_drive_t gpioDrive, pinDrive;
  int err_count, n_compared;
  fan_tach_speed_monitor u_fan_tach_speed_monitor (.clk, .rst_b, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .tachPinIn, .gpioDrive, .pinBitCtrl,
    .bypassValue, .pinDrive, .intOut_b);
  fan_tach_model u_fan_tach_model (.clk, .runFan, .halfCycles, .tachPinIn);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic busWrite(input logic [6:0] idx, input logic [7:0] d);
    @(posedge clk);
    address <= {idx, 2'h0};
    writedata <= {24'h0, d};
    write <= 1'b1;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    write <= 1'b0;
  endtask
  task automatic busRead(input logic [6:0] idx);
    @(posedge clk);
    address <= {idx, 2'h0};
    read <= 1'b1;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata[7:0];
    read <= 1'b0;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic checkNear(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (!(got === exp || got === exp - 8'h01 || got === exp + 8'h01)) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results;
    $display("compared %0d, wrong %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic testRegs;
    busRead(`IDX_SPEED_CONTROL);
    check("control", 8'h00, rd);
    busRead(`IDX_SPEED_COUNT);
    check("count", 8'h00, rd);
    byteenable <= 4'hE;
    busWrite(`IDX_SPEED_CONTROL, 8'hC3);
    byteenable <= 4'hF;
    busRead(`IDX_SPEED_CONTROL);
    check("lane off", 8'h00, rd);
    busWrite(`IDX_SPEED_CONTROL, 8'h7F);
    busRead(`IDX_SPEED_CONTROL);
    check("control", 8'h43, rd);
    repeat (3) @(posedge clk);
    check("pin", {6'h0, gpioDrive}, {6'h0, pinDrive});
    check("irq", 8'h01, {7'h0, intOut_b});
    busWrite(`IDX_SPEED_COUNT, 8'h55);
    busRead(`IDX_SPEED_COUNT);
    check("count ro", 8'h00, rd);
    busRead(7'h10);
    check("unmapped", 8'h00, rd);
  endtask
  task automatic testPolled;
    busWrite(`IDX_SPEED_CONTROL, 8'h80);
    runFan <= 1'b1;
    busRead(`IDX_SPEED_COUNT);
    check("count", 8'h00, rd);
    check("pin oe", 8'h00, {7'h0, pinDrive.oe});
    repeat (25000) @(posedge clk);
    busRead(`IDX_SPEED_COUNT);
    checkNear("count div1", 8'h0A, rd);
    busWrite(`IDX_SPEED_CONTROL, 8'h81);
    repeat (27000) @(posedge clk);
    busRead(`IDX_SPEED_COUNT);
    checkNear("count div2", 8'h05, rd);
  endtask
  task automatic testInterrupt;
    busWrite(`IDX_SPEED_LIMIT, 8'h03);
    busWrite(`IDX_SPEED_CONTROL, 8'hC0);
    repeat (6000) @(posedge clk);
    check("irq", 8'h00, {7'h0, intOut_b});
    busRead(`IDX_INT_SOURCE);
    check("source", 8'h4C, rd);
    busRead(`IDX_SPEED_COUNT);
    held = rd;
    repeat (13000) @(posedge clk);
    busRead(`IDX_SPEED_COUNT);
    check("frozen", held, rd);
    busWrite(`IDX_INT_SOURCE, 8'h00);
    repeat (2) @(posedge clk);
    check("irq clear", 8'h01, {7'h0, intOut_b});
    busRead(`IDX_SPEED_COUNT);
    check("count clear", 8'h00, rd);
  endtask
  task automatic testBypass;
    busWrite(`IDX_SPEED_CONTROL, 8'h00);
    pinBitCtrl <= 8'h20;
    bypassValue <= 1'b1;
    repeat (3) @(posedge clk);
    check("irq off", 8'h01, {7'h0, intOut_b});
    busWrite(`IDX_SPEED_CONTROL, 8'h80);
    repeat (3) @(posedge clk);
    check("bypass", 8'h03, {6'h0, pinDrive});
    pinBitCtrl <= 8'h40;
    bypassValue <= 1'b0;
    repeat (3) @(posedge clk);
    check("bypass", 8'h01, {6'h0, pinDrive});
    pinBitCtrl <= 8'h00;
    repeat (3) @(posedge clk);
    check("pin oe", 8'h00, {7'h0, pinDrive.oe});
  endtask
  initial begin
    rst_b = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 9'h000;
    writedata = 32'h0;
    byteenable = 4'hF;
    gpioDrive = 2'h3;
    pinBitCtrl = 8'h00;
    bypassValue = 1'b0;
    runFan = 1'b0;
    halfCycles = 16'h0C35;
    err_count = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    testRegs;
    testPolled;
    testInterrupt;
    testBypass;
    results;
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    $display("watchdog expired");
    results;
  end
endmodule
